// ---- rtl/pss_supervisor.sv ----
/*
  pss_supervisor: memory enable gating, supply/pushbutton/watchdog reset,
  converter control and the three-wire register link.
  Assumes every pin input is asynchronous to clk; the analog inputs arrive as
  8-bit codes from a sampler and change slowly against the 10 ms slot.
*/
// How it works
// RL1: with enable in low, byte enables low pull matching memory enable outputs low.
// RL2: supply below trip forces memory enables high and memory supply to battery.
// RL3: after supply returns, memory stays blocked until recovery interval ends.
// RL4: supply out of tolerance drives the system reset line low.
// RL5: on recovery reset holds 250 ms, plus oscillator start when osc_disable set.
// RL6: outside reset, a falling edge on the line starts a 250 ms debounce pull.
// RL7: if still low after debounce, wait for release, then pull low 250 ms.
// RL8: strobe falling edge restarts watchdog; expiry pulls reset low 250 ms.
// RL9: watchdog counts its period as soon as reset goes inactive.
// RL10: period bits select 250, 500 or 1000 ms; 01 is 250; 00 disables.
// RL11: at power-up the watchdog runs with the 1000 ms period.
// RL12: host must strobe the watchdog faster than the shortest timeout.
// RL13: code 00 means ground, ff means reference, linear between.
// RL14: select 00 stops converter; otherwise results come within 488 ms, every 10 ms.
// RL15: a changed input select is taken at the next 10 ms slot.
// RL16: update-pending bit is 1 if an update comes soon, 0 if none for 244 ms.
// RL17: a serial read of the converter register defers its update until done.
// RL18: host should poll the pending bit before reading the converter register.
// RL19: chip select high starts a transfer; low ends it and floats data.
// RL20: input bits sampled at rising serial clock; outputs change after falling.
// RL21: bytes move lsb first; command byte first, top bit 0 means read.
// RL22: each data byte advances the address; after 0e it wraps to 00.
// RL23: command bits 6..0 are the address; top bit 1 means write.
// RL24: select 01, 10, 11 pick inputs 0, 1, 2.
// RL25: period pattern 10 gives 500 ms, pattern 11 gives 1000 ms.
// RL26: watchdog counter is cleared whenever reset is active.
`timescale 1ns/1ps
module pss_supervisor import pss_pkg::*; #(
  parameter int MS_TICK_CYCLES = MS_CYCLES,
  parameter int OSC_MS         = OSC_START_MS,
  parameter int FIFO_DEPTH     = 32
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // supply monitor and backup switch
  input  wire logic       supply_ok,
  output logic            mem_supply_on_battery,
  // memory enables, all active low
  input  wire logic       mem_enable_in_n,
  input  wire logic       upper_byte_enable_n,
  input  wire logic       lower_byte_enable_n,
  output logic            mem_enable_out_low_n,
  output logic            mem_enable_out_high_n,
  // system reset line, open drain
  input  wire logic       sys_reset_in_n,
  output logic            sys_reset_out_n,
  output logic            sys_reset_oe,
  // watchdog
  input  wire logic       watchdog_strobe_n,
  // converter inputs as sampled codes
  input  wire logic [7:0] analog_in_0,
  input  wire logic [7:0] analog_in_1,
  input  wire logic [7:0] analog_in_2,
  // three-wire link
  input  wire logic       ser_cs,
  input  wire logic       ser_clk,
  input  wire logic       ser_data_in,
  output logic            ser_data_out,
  output logic            ser_data_oe
);
  localparam int PW = $clog2(MS_TICK_CYCLES + 1);

  typedef struct packed {
    logic [1:0]            sup_s, cs_s, sck_s, sdi_s, stb_s, rsl_s, mei_s, ube_s, lbe_s;
    logic [2:0][7:0]       ain_a, ain_b;
    logic                  sck_d, stb_d, rsl_d;
    logic [PW-1:0]         pre;
    logic                  tick;
    pss_rst_state_type     rs;
    logic [10:0]           rcnt;
    logic [2:0]            settle;
    logic                  pu_block, rst_oe, rst_lvl;
    logic [10:0]           wcnt;
    logic [7:0]            ctrl, wd, adc, sample;
    logic [3:0]            slot;
    logic                  push;
    pss_ser_state_type     ss;
    logic [6:0]            addr, rd_addr;
    logic [2:0]            idx;
    logic [7:0]            sh, tx;
    logic                  sdo, sdo_oe;
    logic                  ceo_l, ceo_h, on_batt;
  } pss_state_type;

  pss_state_type q;
  pss_state_type next_q;
  logic          fifo_in_ready;
  logic          fifo_out_valid;
  logic [7:0]    fifo_out_data;
  logic          adc_lock;

  // period in ms for the two period bits
  function automatic logic [10:0] wd_period(input logic [1:0] td);
    case (td)
      2'b01:   wd_period = 11'(WD_SHORT_MS);  // [RL10]
      2'b10:   wd_period = 11'(WD_MID_MS);    // [RL25]
      2'b11:   wd_period = 11'(WD_LONG_MS);   // [RL25]
      default: wd_period = 11'h000;
    endcase
  endfunction

  // burst address step, shared by reads and writes
  function automatic logic [6:0] next_addr(input logic [6:0] a);
    next_addr = (a == REG_ADC) ? 7'h00 : a + 7'h01;  // [RL22]
  endfunction

  // converter results queue here while a read holds the register
  pss_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (q.push),
    .in_data   (q.sample),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (!adc_lock)
  );

  assign adc_lock = (q.ss == SS_READ) && (q.rd_addr == REG_ADC);  // [RL17]

  assign mem_supply_on_battery = q.on_batt;
  assign mem_enable_out_low_n  = q.ceo_l;
  assign mem_enable_out_high_n = q.ceo_h;
  assign sys_reset_out_n       = q.rst_lvl;
  assign sys_reset_oe          = q.rst_oe;
  assign ser_data_out          = q.sdo;
  assign ser_data_oe           = q.sdo_oe;

  // whole next state; synchronisers feed only their own second stage
  always_comb begin
    logic        blk;
    logic        sck_rise;
    logic        sck_fall;
    logic        pb_fall;
    logic        stb_fall;
    logic [7:0]  byte_in;
    logic [7:0]  rd_val;
    logic [10:0] per;
    blk      = 1'b0;
    sck_rise = 1'b0;
    sck_fall = 1'b0;
    pb_fall  = 1'b0;
    stb_fall = 1'b0;
    byte_in  = 8'h00;
    rd_val   = 8'h00;
    per      = 11'h000;
    next_q   = q;
    next_q.sup_s = {q.sup_s[0], supply_ok};
    next_q.cs_s  = {q.cs_s[0], ser_cs};
    next_q.sck_s = {q.sck_s[0], ser_clk};
    next_q.sdi_s = {q.sdi_s[0], ser_data_in};
    next_q.stb_s = {q.stb_s[0], watchdog_strobe_n};
    next_q.rsl_s = {q.rsl_s[0], sys_reset_in_n};
    next_q.mei_s = {q.mei_s[0], mem_enable_in_n};
    next_q.ube_s = {q.ube_s[0], upper_byte_enable_n};
    next_q.lbe_s = {q.lbe_s[0], lower_byte_enable_n};
    next_q.ain_a = {analog_in_2, analog_in_1, analog_in_0};
    next_q.ain_b = q.ain_a;
    next_q.sck_d = q.sck_s[1];
    next_q.stb_d = q.stb_s[1];
    next_q.rsl_d = q.rsl_s[1];
    sck_rise = q.sck_s[1] && !q.sck_d;
    sck_fall = !q.sck_s[1] && q.sck_d;
    pb_fall  = !q.rsl_s[1] && q.rsl_d;
    stb_fall = !q.stb_s[1] && q.stb_d;

    // millisecond time base
    next_q.tick = (q.pre == PW'(MS_TICK_CYCLES - 1));
    next_q.pre  = next_q.tick ? '0 : q.pre + 1'b1;

    // reset supervisor; supply loss preempts every state
    if (q.rcnt != 11'h000 && q.tick) begin
      next_q.rcnt = q.rcnt - 11'h001;
    end
    case (q.rs)
      RS_PFAIL: begin
        if (q.sup_s[1]) begin
          next_q.rs   = RS_HOLD;
          next_q.rcnt = q.ctrl[CTRL_OSC_BIT] ? 11'(RESET_HOLD_MS + OSC_MS)
                                             : 11'(RESET_HOLD_MS);  // [RL5]
        end
      end
      RS_HOLD: begin
        if (q.rcnt == 11'h000) begin
          next_q.rs       = RS_RUN;
          next_q.pu_block = 1'b0;  // [RL3]
        end
      end
      RS_RUN: begin
        per = wd_period(q.wd[1:0]);
        if (pb_fall) begin
          next_q.rs   = RS_PB_DEB;  // [RL6]
          next_q.rcnt = 11'(RESET_HOLD_MS);
        end else if (per != 11'h000 && stb_fall) begin
          next_q.wcnt = 11'h000;  // [RL8]
        end else if (per != 11'h000 && q.tick) begin
          // counting starts from zero at release of reset [RL9]
          if (q.wcnt + 11'h001 >= per) begin
            next_q.rs   = RS_HOLD;  // [RL8]
            next_q.rcnt = 11'(RESET_HOLD_MS);
          end else begin
            next_q.wcnt = q.wcnt + 11'h001;
          end
        end
      end
      RS_PB_DEB: begin
        next_q.settle = PB_SETTLE_CYCLES;
        if (q.rcnt == 11'h000) begin
          next_q.rs = RS_PB_CHK;
        end
      end
      RS_PB_CHK: begin
        // the line needs a few cycles to show its own level once released
        next_q.settle = q.settle - 3'h1;
        if (q.settle == 3'h0) begin
          next_q.rs = q.rsl_s[1] ? RS_RUN : RS_PB_REL;  // [RL7]
        end
      end
      RS_PB_REL: begin
        if (q.rsl_s[1]) begin
          next_q.rs   = RS_HOLD;  // [RL7]
          next_q.rcnt = 11'(RESET_HOLD_MS);
        end
      end
      default: next_q.rs = RS_PFAIL;
    endcase
    if (!q.sup_s[1]) begin
      next_q.rs       = RS_PFAIL;  // [RL4]
      next_q.pu_block = 1'b1;      // [RL3]
    end
    if (next_q.rs != RS_RUN) begin
      next_q.wcnt = 11'h000;  // [RL26]
    end
    next_q.rst_oe  = (next_q.rs != RS_RUN) && (next_q.rs != RS_PB_CHK)
                     && (next_q.rs != RS_PB_REL);
    next_q.rst_lvl = 1'b0;

    // memory enable gating and backup switch
    blk            = q.pu_block || !q.sup_s[1];                    // [RL2] [RL3]
    next_q.ceo_l   = blk || q.mei_s[1] || q.lbe_s[1];             // [RL1]
    next_q.ceo_h   = blk || q.mei_s[1] || q.ube_s[1];             // [RL1]
    next_q.on_batt = !q.sup_s[1];                                 // [RL2]

    // converter: each 10 ms slot reads the current select and takes one sample
    if (q.push && fifo_in_ready) begin
      next_q.push = 1'b0;
    end
    if (q.ctrl[CTRL_AIS_HI:CTRL_AIS_LO] == 2'b00) begin
      next_q.slot = 4'h0;  // [RL14]
    end else if (q.tick && !(q.push && !fifo_in_ready)) begin
      if (q.slot == 4'(ADC_SLOT_MS - 1)) begin
        next_q.slot    = 4'h0;
        next_q.sample  = q.ain_b[q.ctrl[CTRL_AIS_HI:CTRL_AIS_LO] - 2'b01];  // [RL24] [RL13] [RL15]
        next_q.push    = 1'b1;  // [RL14]
      end else begin
        next_q.slot = q.slot + 4'h1;
      end
    end
    if (fifo_out_valid && !adc_lock) begin
      next_q.adc = fifo_out_data;  // [RL17]
    end

    // register read view
    case (q.addr)
      REG_CTRL: rd_val = q.ctrl;
      REG_STAT: rd_val = {q.ctrl[CTRL_AIS_HI:CTRL_AIS_LO] != 2'b00 || fifo_out_valid
                          || q.push, 7'h00};  // [RL16]
      REG_WD:   rd_val = q.wd;
      REG_ADC:  rd_val = q.adc;
      default:  rd_val = 8'h00;
    endcase

    // three-wire link
    byte_in = {q.sdi_s[1], q.sh[7:1]};  // [RL21]
    case (q.ss)
      SS_IDLE: begin
        if (q.cs_s[1]) begin
          next_q.ss  = SS_CMD;  // [RL19]
          next_q.idx = 3'h0;
        end
      end
      SS_CMD: begin
        if (sck_rise) begin
          next_q.sh  = byte_in;  // [RL20]
          next_q.idx = q.idx + 3'h1;
          if (q.idx == 3'h7) begin
            next_q.addr = byte_in[6:0];  // [RL23]
            next_q.ss   = byte_in[CMD_WR_BIT] ? SS_WRITE : SS_READ;  // [RL21] [RL23]
          end
        end
      end
      SS_READ: begin
        if (sck_fall) begin
          next_q.sdo_oe = 1'b1;
          next_q.idx    = q.idx + 3'h1;
          if (q.idx == 3'h0) begin
            next_q.tx      = rd_val;
            next_q.rd_addr = q.addr;
            next_q.sdo     = rd_val[0];  // [RL20] [RL21]
            next_q.addr    = next_addr(q.addr);  // [RL22]
          end else begin
            next_q.sdo = q.tx[q.idx];
          end
        end
      end
      SS_WRITE: begin
        if (sck_rise) begin
          next_q.sh  = byte_in;
          next_q.idx = q.idx + 3'h1;
          if (q.idx == 3'h7) begin
            if (q.addr == REG_CTRL) begin
              next_q.ctrl = byte_in & CTRL_MASK;
            end else if (q.addr == REG_WD && !q.ctrl[CTRL_WP_BIT]) begin
              next_q.wd = byte_in & WD_MASK;  // [RL10]
            end
            next_q.addr = next_addr(q.addr);  // [RL22]
          end
        end
      end
      default: next_q.ss = SS_IDLE;
    endcase
    if (!q.cs_s[1]) begin
      next_q.ss      = SS_IDLE;  // [RL19]
      next_q.sdo_oe  = 1'b0;
      next_q.rd_addr = 7'h7f;
    end
  end

  // one register bank for all state; power-up defaults
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q          <= '0;
      q.ctrl     <= CTRL_RESET;
      q.wd       <= WD_RESET;  // [RL11]
      q.rs       <= RS_PFAIL;
      q.pu_block <= 1'b1;
      q.rst_oe   <= 1'b1;
      q.ceo_l    <= 1'b1;
      q.ceo_h    <= 1'b1;
      q.on_batt  <= 1'b1;
      q.rd_addr  <= 7'h7f;
    end else begin
      q <= next_q;
    end
  end

  property p_ceo_word;
    @(posedge clk) disable iff (!resetn)
    (!q.pu_block && q.sup_s[1] && !q.mei_s[1] && !q.lbe_s[1] && !q.ube_s[1])
      |=> (!mem_enable_out_low_n && !mem_enable_out_high_n);
  endproperty
  a_ceo_word: assert property (p_ceo_word) else $error("word enable not passed"); // [RL1]

  property p_pfail_block;
    @(posedge clk) disable iff (!resetn)
    !q.sup_s[1] |=> (mem_enable_out_low_n && mem_enable_out_high_n
                     && mem_supply_on_battery && sys_reset_oe);
  endproperty
  a_pfail_block: assert property (p_pfail_block) else $error("supply loss not handled"); // [RL2]

  property p_pu_block;
    @(posedge clk) disable iff (!resetn)
    q.pu_block |=> (mem_enable_out_low_n && mem_enable_out_high_n);
  endproperty
  a_pu_block: assert property (p_pu_block) else $error("memory open during recovery"); // [RL3]

  property p_pfail_rst;
    @(posedge clk) disable iff (!resetn)
    (q.rs == RS_PFAIL) |-> sys_reset_oe;
  endproperty
  a_pfail_rst: assert property (p_pfail_rst) else $error("reset not driven on fail"); // [RL4]

  property p_recover_hold;
    @(posedge clk) disable iff (!resetn)
    (q.rs == RS_PFAIL && q.sup_s[1] && !q.ctrl[CTRL_OSC_BIT])
      |=> (q.rs == RS_HOLD && q.rcnt == 11'(RESET_HOLD_MS));
  endproperty
  a_recover_hold: assert property (p_recover_hold) else $error("wrong recovery hold"); // [RL5]

  property p_pb_start;
    @(posedge clk) disable iff (!resetn)
    (q.rs == RS_RUN && q.sup_s[1] && !q.rsl_s[1] && q.rsl_d)
      |=> (q.rs == RS_PB_DEB && sys_reset_oe);
  endproperty
  a_pb_start: assert property (p_pb_start) else $error("pushbutton edge missed"); // [RL6]

  property p_wd_expire;
    @(posedge clk) disable iff (!resetn)
    (q.rs == RS_RUN && q.sup_s[1] && q.rsl_s[1] && q.tick && q.wd[1:0] == 2'b01
     && q.wcnt == 11'(WD_SHORT_MS - 1) && !(!q.stb_s[1] && q.stb_d))
      |=> (q.rs == RS_HOLD && q.rcnt == 11'(RESET_HOLD_MS));
  endproperty
  a_wd_expire: assert property (p_wd_expire) else $error("watchdog expiry missed"); // [RL8]

  property p_wd_clear;
    @(posedge clk) disable iff (!resetn)
    (q.rs != RS_RUN) |-> (q.wcnt == 11'h000);
  endproperty
  a_wd_clear: assert property (p_wd_clear) else $error("watchdog count kept in reset"); // [RL26]

  property p_adc_hold;
    @(posedge clk) disable iff (!resetn)
    adc_lock |=> $stable(q.adc);
  endproperty
  a_adc_hold: assert property (p_adc_hold) else $error("converter changed mid read"); // [RL17]

  property p_cs_float;
    @(posedge clk) disable iff (!resetn)
    !q.cs_s[1] |=> !ser_data_oe;
  endproperty
  a_cs_float: assert property (p_cs_float) else $error("data driven without select"); // [RL19]

  property p_wrap;
    @(posedge clk) disable iff (!resetn)
    (q.cs_s[1] && q.ss == SS_WRITE && q.sck_s[1] && !q.sck_d && q.idx == 3'h7
     && q.addr == REG_ADC) |=> (q.addr == 7'h00);
  endproperty
  a_wrap: assert property (p_wrap) else $error("address did not wrap"); // [RL22]

  c_pb_release: cover property (@(posedge clk) disable iff (!resetn)
    q.rs == RS_PB_REL ##1 q.rs == RS_HOLD);
  c_wd_expire: cover property (@(posedge clk) disable iff (!resetn)
    q.rs == RS_RUN ##1 q.rs == RS_HOLD);
  c_adc_update: cover property (@(posedge clk) disable iff (!resetn)
    fifo_out_valid && !adc_lock);
  c_read_adc: cover property (@(posedge clk) disable iff (!resetn)
    adc_lock && fifo_out_valid);
endmodule

// ---- rtl/pss_pkg.sv ----
/*
  pss_pkg: shared constants and types of the portable system supervisor.
  Assumes a 100 MHz core clock; all long intervals are counted in
  millisecond ticks produced by one prescaler in the top module.
*/
package pss_pkg;

  // core clock and millisecond time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_IN_NS      = 1000000;
  localparam int MS_CYCLES     = MS_IN_NS / CLK_PERIOD_NS;

  // supervisor intervals, in milliseconds
  localparam int RESET_HOLD_MS    = 250;
  localparam int OSC_START_MS     = 1000;
  localparam int WD_SHORT_MS      = 250;
  localparam int WD_MID_MS        = 500;
  localparam int WD_LONG_MS       = 1000;
  localparam int ADC_SLOT_MS      = 10;
  localparam int ADC_FIRST_MAX_MS = 488;
  localparam int UPD_QUIET_MS     = 244;

  // cycles allowed for the released reset line to settle through the synchroniser
  localparam logic [2:0] PB_SETTLE_CYCLES = 3'h4;

  // serial register map
  localparam logic [6:0] REG_CTRL = 7'h0b;
  localparam logic [6:0] REG_STAT = 7'h0c;
  localparam logic [6:0] REG_WD   = 7'h0d;
  localparam logic [6:0] REG_ADC  = 7'h0e;

  // field positions
  localparam int CTRL_OSC_BIT = 7;
  localparam int CTRL_WP_BIT  = 6;
  localparam int CTRL_AIS_HI  = 5;
  localparam int CTRL_AIS_LO  = 4;
  localparam int STAT_UPD_BIT = 7;
  localparam int CMD_WR_BIT   = 7;

  // writable bits and power-up values
  localparam logic [7:0] CTRL_MASK  = 8'hf0;
  localparam logic [7:0] WD_MASK    = 8'h03;
  localparam logic [7:0] CTRL_RESET = 8'h80;
  localparam logic [7:0] WD_RESET   = 8'h03;

  // reset supervisor states
  typedef enum logic [2:0] {
    RS_PFAIL  = 3'b000,
    RS_HOLD   = 3'b001,
    RS_RUN    = 3'b010,
    RS_PB_DEB = 3'b011,
    RS_PB_CHK = 3'b100,
    RS_PB_REL = 3'b101
  } pss_rst_state_type;

  // serial link states
  typedef enum logic [1:0] {
    SS_IDLE  = 2'b00,
    SS_CMD   = 2'b01,
    SS_READ  = 2'b10,
    SS_WRITE = 2'b11
  } pss_ser_state_type;

endpackage

// ---- rtl/pss_fifo.sv ----
/*
  pss_fifo: small synchronous FIFO with a registered read port.
  Assumes one clock; valid/ready on both sides; the output register is a
  stage of its own, so up to DEPTH words sit in storage plus one at the output.
*/
`timescale 1ns/1ps
module pss_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wp;
    logic [AW:0]                 rp;
    logic                        ov;
    logic [WIDTH-1:0]            od;
  } pss_fifo_state_type;

  pss_fifo_state_type q;
  pss_fifo_state_type next_q;
  logic [AW:0]        fill;
  logic               stored;
  logic               load;

  // honest full and empty from the pointer difference
  assign fill      = q.wp - q.rp;
  assign stored    = (fill != '0);
  assign in_ready  = (fill != (AW+1)'(DEPTH));
  assign out_valid = q.ov;
  assign out_data  = q.od;
  assign load      = stored && (!q.ov || out_ready);

  // pointer and output register update
  always_comb begin
    next_q = q;
    if (in_valid && in_ready) begin
      next_q.mem[q.wp[AW-1:0]] = in_data;
      next_q.wp                = q.wp + 1'b1;
    end
    if (load) begin
      next_q.od = q.mem[q.rp[AW-1:0]];
      next_q.ov = 1'b1;
      next_q.rp = q.rp + 1'b1;
    end else if (out_ready) begin
      next_q.ov = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule

// ---- verif/pss_host.sv ----
/*
  pss_host: host end of the three-wire register link.
  Assumes the core clock paces every link edge; 80 ns serial clock period.
*/
`timescale 1ns/1ps
module pss_host (
  // pacing clock
  input  wire logic clk,
  // link to the device
  output logic      ser_cs,
  output logic      ser_clk,
  output logic      ser_data_in,
  input  wire logic ser_data_out,
  input  wire logic ser_data_oe
);
  // link idle: select low, clock parked low
  initial begin
    ser_cs      = 1'b0;
    ser_clk     = 1'b0;
    ser_data_in = 1'b0;
  end

  // select rises with the serial clock low
  task automatic open_link();
    @(posedge clk);
    ser_cs <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  // one byte lsb first; when not driving, toggle so no stale level is seen
  task automatic byte_io(input logic [7:0] tx, input bit drv, output logic [7:0] rx);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      ser_clk     <= 1'b0;
      ser_data_in <= drv ? tx[i] : ~ser_data_in;
      repeat (4) @(posedge clk);
      ser_clk <= 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      rx[i] = ser_data_oe ? ser_data_out : 1'bx;
    end
  endtask

  // lowering select ends the transfer at once
  task automatic close_link();
    @(posedge clk);
    ser_clk <= 1'b0;
    repeat (4) @(posedge clk);
    ser_cs <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule

// ---- verif/testbench.sv ----
/*
  testbench: self-checking bench of pss_supervisor with a host model.
  Assumes 10 clk cycles per ms tick and a short oscillator start.
*/
`timescale 1ns/1ps
module testbench;
  import pss_pkg::*;
  logic       clk, resetn, supply_ok, on_bat, me_n, ub_n, lb_n, ceo_lo, ceo_hi;
  logic       pb_low, rst_out, rst_oe, kick_on, strobe_n, cs, sclk, sdi, sdo, soe;
  wire        rst_line;
  logic [7:0] r0, r1;
  int         n_fail, check_count, n;
  // {enable in, upper, lower, out low, out high}
  logic [4:0] rows [5] = '{5'b00000, 5'b00110, 5'b01001, 5'b01111, 5'b10011};

  // open-drain reset line with pull-up, pushbutton on it
  assign rst_line = !(rst_oe && !rst_out) && !pb_low;

  pss_supervisor #(.MS_TICK_CYCLES(10), .OSC_MS(10)) DUT (
    .clk(clk), .resetn(resetn), .supply_ok(supply_ok), .mem_supply_on_battery(on_bat),
    .mem_enable_in_n(me_n), .upper_byte_enable_n(ub_n), .lower_byte_enable_n(lb_n),
    .mem_enable_out_low_n(ceo_lo), .mem_enable_out_high_n(ceo_hi),
    .sys_reset_in_n(rst_line), .sys_reset_out_n(rst_out), .sys_reset_oe(rst_oe),
    .watchdog_strobe_n(strobe_n), .analog_in_0(8'h5a), .analog_in_1(8'ha5),
    .analog_in_2(8'hc3), .ser_cs(cs), .ser_clk(sclk), .ser_data_in(sdi),
    .ser_data_out(sdo), .ser_data_oe(soe));

  pss_host host (.clk(clk), .ser_cs(cs), .ser_clk(sclk), .ser_data_in(sdi),
    .ser_data_out(sdo), .ser_data_oe(soe));

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // command then two data bytes, so every burst crosses one address
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] d);
    host.open_link();
    host.byte_io(cmd, 1'b1, r0);
    host.byte_io(d, cmd[7], r0);
    host.byte_io(d, cmd[7], r1);
    host.close_link();
  endtask

  // count cycles while the reset pull holds a given level
  task automatic wait_oe(input logic lvl);
    for (n = 0; n < 4000 && rst_oe === lvl; n++) @(posedge clk);
  endtask

  task automatic give_verdict();
    if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // host strobe every ~500 cycles, well inside the shortest period
  initial begin
    strobe_n = 1'b1;
    forever begin
      repeat (500) @(posedge clk);
      if (kick_on) strobe_n <= 1'b0;
      repeat (4) @(posedge clk);
      strobe_n <= 1'b1;
    end
  end

  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    give_verdict();
  end

  initial begin
    {resetn, supply_ok, me_n, ub_n, lb_n, pb_low, kick_on} = 7'b0100000;
    n_fail = 0;
    check_count = 0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (100) @(posedge clk);
    check("blocked", {ceo_lo, ceo_hi}, 8'h03);
    wait_oe(1'b1);
    check("hold", (n > 2420 && n < 2560), 8'h01);
    kick_on <= 1'b1;
    // gating table, one row at a time
    foreach (rows[i]) begin
      @(posedge clk);
      {me_n, ub_n, lb_n} <= rows[i][4:2];
      repeat (6) @(posedge clk);
      check("ceo", {ceo_lo, ceo_hi}, rows[i][1:0]);
    end
    xfer(8'h0d, 8'h00);
    check("wd_reset", r0, 8'h03);
    xfer(8'h8b, 8'h00);
    xfer(8'h8d, 8'h01);
    xfer(8'h8b, 8'h10);
    repeat (2500) @(posedge clk);
    xfer(8'h0c, 8'h00);
    check("status", r0, 8'h80);
    check("wd", r1, 8'h01);
    xfer(8'h0e, 8'h00);
    check("adc0", r0, 8'h5a);
    check("wrap", r1, 8'h00);
    check("float", soe, 8'h00);
    xfer(8'h8b, 8'h30);
    repeat (2500) @(posedge clk);
    xfer(8'h0e, 8'h00);
    check("adc2", r0, 8'hc3);
    // starve the watchdog: 250 ms period, then a 250 ms pull
    kick_on <= 1'b0;
    wait_oe(1'b0);
    check("wd_fire", (n > 1900 && n < 2600), 8'h01);
    wait_oe(1'b1);
    check("wd_hold", (n > 2470 && n < 2530), 8'h01);
    // pushbutton held past the debounce, then released
    repeat (10) @(posedge clk);
    pb_low <= 1'b1;
    repeat (10) @(posedge clk);
    check("pb", rst_oe, 8'h01);
    repeat (2600) @(posedge clk);
    check("pb_wait", rst_oe, 8'h00);
    pb_low <= 1'b0;
    repeat (10) @(posedge clk);
    check("pb_rel", rst_oe, 8'h01);
    wait_oe(1'b1);
    check("pb_hold", (n > 2460 && n < 2530), 8'h01);
    supply_ok <= 1'b0;
    repeat (8) @(posedge clk);
    check("pfail", {5'h0, on_bat, ceo_lo, ceo_hi}, 8'h07);
    check("pf_rst", rst_oe, 8'h01);
    // supply back with the oscillator bit clear: plain hold, memory still blocked
    supply_ok <= 1'b1;
    repeat (100) @(posedge clk);
    check("rec_block", {5'h0, on_bat, ceo_lo, ceo_hi}, 8'h03);
    wait_oe(1'b1);
    check("rec_hold", (n > 2380 && n < 2430), 8'h01);
    give_verdict();
  end
endmodule
